// ===== rtl/mpio_params.svh
// register indices, field positions and reset values for the ports
`ifndef MPIO_PARAMS_SVH
`define MPIO_PARAMS_SVH

// word index on the bus; byte address is four times the index
`define MPIO_ADDR_W             8
`define MPIO_IDX_INT_PORT       8'h02
`define MPIO_IDX_SIX_PORT       8'h03
`define MPIO_IDX_PWM_PORT       8'h04
`define MPIO_IDX_MIXED_PORT     8'h05
`define MPIO_IDX_VIDEO_PORT     8'h06
`define MPIO_IDX_MIXED_DIR      8'h08
`define MPIO_IDX_PWM_DIR        8'h0C
`define MPIO_IDX_VIDEO_DIR      8'h0D
`define MPIO_IDX_SIX_DIR        8'h2B
`define MPIO_IDX_CTRL           8'h40
`define MPIO_IDX_VIDEO_SEL      8'h41
// index bit that turns a port read into the latch view
`define MPIO_RMW_BIT            7

// control register fields
`define MPIO_CTRL_SIX_OD_LSB    0
`define MPIO_CTRL_MIXED_OD_LSB  2
`define MPIO_CTRL_MIXED_TOP     4
`define MPIO_CTRL_TEST_VIDEO    5
`define MPIO_CTRL_W             6
`define MPIO_CTRL_RST           6'h00
`define MPIO_VIDEO_SEL_RST      8'h00

// open-drain capable bit positions and the mixed top bit
`define MPIO_SIX_OD_BIT0        4
`define MPIO_MIXED_OD_BIT0      1
`define MPIO_MIXED_TOP_BIT      7
`define MPIO_VIDEO_OD_BITS      4

// port reset values
`define MPIO_LATCH_RST          8'hFF
`define MPIO_DIR_RST            8'h00
`define MPIO_INT_LATCH_RST      1'b1

`endif

// ===== rtl/mpio_pkg.sv
// types and shared decoding for the parallel port block
`default_nettype none

package mpio_pkg;

   typedef enum logic [0:0] {
      MPIO_BUS_SAMPLE = 1'b0,
      MPIO_BUS_ANSWER = 1'b1
   } mpio_bus_state_t;

   typedef logic [7:0] mpio_byte_t;

   // read view of a port: pins normally, latch for output bits on rmw view
   function automatic mpio_byte_t mpio_read_view(input mpio_byte_t pin,
                                                 input mpio_byte_t latch,
                                                 input mpio_byte_t dir,
                                                 input logic rmw);
      mpio_byte_t v;
      v = rmw ? ((latch & dir) | (pin & ~dir)) : pin;
      return v;
   endfunction

endpackage

`default_nettype wire

// ===== rtl/mpio_port.sv
// one programmable port: output latch and direction register
`timescale 1ns/10ps
`default_nettype none

module mpio_port
   import mpio_pkg::*;
#(
   parameter int W = 8,
   parameter logic [7:0] LATCH_RST = 8'hFF,
   parameter logic [7:0] DIR_RST = 8'h00
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   // write strobes and data
   input  wire logic         wr_latch,
   input  wire logic         wr_dir,
   input  wire logic [W-1:0] wdata,
   // state
   output logic      [W-1:0] latch_r,
   output logic      [W-1:0] dir_r
);

   logic [W-1:0] latch_nxt;
   logic [W-1:0] dir_nxt;

   if (W < 1 || W > 8) begin : g_chk
      $error("mpio_port width must be 1 to 8");
   end

   always_comb begin
      latch_nxt = latch_r;
      dir_nxt   = dir_r;
      if (wr_latch) begin
         latch_nxt = wdata;
      end
      if (wr_dir) begin
         dir_nxt = wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         latch_r <= LATCH_RST[W-1:0];
         dir_r   <= DIR_RST[W-1:0];
      end else begin
         latch_r <= latch_nxt;
         dir_r   <= dir_nxt;
      end
   end

endmodule // mpio_port

`default_nettype wire

// ===== rtl/mpio_top.sv
// parallel port block: bus slave, latches, pin drive and read views
//
// Behaviour
// - output latches hold data; inputs read live
// - pins sampled in first machine state
// - writes take effect in second machine state
// - read-modify-write reads latch, others read pins
// - interrupt port latch resets to one
// - driven interrupt pin falling edge flags interrupt
// - interrupt port read defines only bit zero
// - direction bit zero input, one output
// - reset clears directions, sets latches all ones
// - latch writes ignore direction setting
// - video low nibble drives needing direction and select or test video; upper nibble needs direction only
// - video low nibble is sink-only open drain
// - mixed bit seven picks intensity or latch
// - video upper nibble picks display or latch
// - input bits read pins, rmw may overwrite
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "mpio_params.svh"

module mpio_top
   import mpio_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    nrst,
   // avalon-mm slave
   input  wire logic [`MPIO_ADDR_W-1:0] avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   // interrupt port pin
   input  wire logic                    interrupt_pin_in,
   output logic                         interrupt_pin_out,
   output logic                         interrupt_pin_oe_n,
   output logic                         ext_int_fall,
   // six-bit port pins
   input  wire logic [5:0]              six_bit_port_in,
   output logic      [5:0]              six_bit_port_out,
   output logic      [5:0]              six_bit_port_oe_n,
   // pwm port pins
   input  wire logic [7:0]              pwm_port_in,
   output logic      [7:0]              pwm_port_out,
   output logic      [7:0]              pwm_port_oe_n,
   // mixed port pins
   input  wire logic [7:0]              mixed_port_in,
   output logic      [7:0]              mixed_port_out,
   output logic      [7:0]              mixed_port_oe_n,
   // video port pins
   input  wire logic [7:0]              video_port_in,
   output logic      [7:0]              video_port_out,
   output logic      [7:0]              video_port_oe_n,
   // peripheral function outputs
   input  wire logic [5:0]              six_func_out,
   input  wire logic [7:0]              pwm_func_out,
   input  wire logic [6:0]              mixed_func_out,
   input  wire logic                    osd_intensity,
   input  wire logic [3:0]              osd_colour,
   input  wire logic [3:0]              test_video_out
);

   // bus state
   mpio_bus_state_t             state_r;
   mpio_bus_state_t             state_nxt;
   logic                        waitreq_r;
   logic                        waitreq_nxt;
   logic [31:0]                 rdata_r;
   logic [31:0]                 rdata_nxt;
   // local control registers
   logic [`MPIO_CTRL_W-1:0]     ctrl_r;
   logic [`MPIO_CTRL_W-1:0]     ctrl_nxt;
   logic [7:0]                  vsel_r;
   logic [7:0]                  vsel_nxt;
   logic                        int_latch_r;
   logic                        int_latch_nxt;
   // pin drive registers
   logic                        int_out_r;
   logic                        int_oe_n_r;
   logic                        int_prev_r;
   logic                        int_fall_r;
   logic [5:0]                  six_out_r;
   logic [5:0]                  six_oe_n_r;
   logic [7:0]                  pwm_out_r;
   logic [7:0]                  pwm_oe_n_r;
   logic [7:0]                  mix_out_r;
   logic [7:0]                  mix_oe_n_r;
   logic [7:0]                  vid_out_r;
   logic [7:0]                  vid_oe_n_r;
   logic [5:0]                  six_out_nxt;
   logic [5:0]                  six_oe_n_nxt;
   logic [7:0]                  pwm_out_nxt;
   logic [7:0]                  pwm_oe_n_nxt;
   logic [7:0]                  mix_out_nxt;
   logic [7:0]                  mix_oe_n_nxt;
   logic [7:0]                  vid_out_nxt;
   logic [7:0]                  vid_oe_n_nxt;
   // decode
   logic                        take_wr;
   logic                        rmw;
   logic [`MPIO_ADDR_W-1:0]     idx;
   logic [7:0]                  wbyte;
   logic                        wr_six;
   logic                        wr_pwm;
   logic                        wr_mix;
   logic                        wr_vid;
   logic                        wr_six_dir;
   logic                        wr_pwm_dir;
   logic                        wr_mix_dir;
   logic                        wr_vid_dir;
   // port state
   logic [5:0]                  six_latch;
   logic [5:0]                  six_dir;
   logic [7:0]                  pwm_latch;
   logic [7:0]                  pwm_dir;
   logic [7:0]                  mix_latch;
   logic [7:0]                  mix_dir;
   logic [7:0]                  vid_latch;
   logic [7:0]                  vid_dir;

   // the rmw alias bit is stripped so both views share one decode
   always_comb begin
      idx = avs_address;
      idx[`MPIO_RMW_BIT] = 1'b0;
   end

   assign rmw     = avs_address[`MPIO_RMW_BIT];
   assign wbyte   = avs_writedata[7:0];
   // write is taken at the edge that ends the first state
   assign take_wr = (state_r == MPIO_BUS_SAMPLE) && avs_write &&
                    avs_byteenable[0] && !rmw;
   assign wr_six     = take_wr && (idx == `MPIO_IDX_SIX_PORT);
   assign wr_pwm     = take_wr && (idx == `MPIO_IDX_PWM_PORT);
   assign wr_mix     = take_wr && (idx == `MPIO_IDX_MIXED_PORT);
   assign wr_vid     = take_wr && (idx == `MPIO_IDX_VIDEO_PORT);
   assign wr_six_dir = take_wr && (idx == `MPIO_IDX_SIX_DIR);
   assign wr_pwm_dir = take_wr && (idx == `MPIO_IDX_PWM_DIR);
   assign wr_mix_dir = take_wr && (idx == `MPIO_IDX_MIXED_DIR);
   assign wr_vid_dir = take_wr && (idx == `MPIO_IDX_VIDEO_DIR);

   mpio_port #(.W(6), .LATCH_RST(`MPIO_LATCH_RST), .DIR_RST(`MPIO_DIR_RST))
      u_six (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .wr_latch (wr_six),
      .wr_dir   (wr_six_dir),
      .wdata    (wbyte[5:0]),
      .latch_r  (six_latch),
      .dir_r    (six_dir)
   );

   mpio_port #(.W(8), .LATCH_RST(`MPIO_LATCH_RST), .DIR_RST(`MPIO_DIR_RST))
      u_pwm (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .wr_latch (wr_pwm),
      .wr_dir   (wr_pwm_dir),
      .wdata    (wbyte),
      .latch_r  (pwm_latch),
      .dir_r    (pwm_dir)
   );

   mpio_port #(.W(8), .LATCH_RST(`MPIO_LATCH_RST), .DIR_RST(`MPIO_DIR_RST))
      u_mix (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .wr_latch (wr_mix),
      .wr_dir   (wr_mix_dir),
      .wdata    (wbyte),
      .latch_r  (mix_latch),
      .dir_r    (mix_dir)
   );

   mpio_port #(.W(8), .LATCH_RST(`MPIO_LATCH_RST), .DIR_RST(`MPIO_DIR_RST))
      u_vid (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .wr_latch (wr_vid),
      .wr_dir   (wr_vid_dir),
      .wdata    (wbyte),
      .latch_r  (vid_latch),
      .dir_r    (vid_dir)
   );

   // bus sequencing and local registers
   always_comb begin
      state_nxt     = state_r;
      waitreq_nxt   = 1'b1;
      rdata_nxt     = rdata_r;
      ctrl_nxt      = ctrl_r;
      vsel_nxt      = vsel_r;
      int_latch_nxt = int_latch_r;
      unique case (state_r)
         MPIO_BUS_SAMPLE: begin
            if (avs_read || avs_write) begin
               state_nxt   = MPIO_BUS_ANSWER;
               waitreq_nxt = 1'b0;
            end
            if (avs_read) begin
               rdata_nxt = 32'h0000_0000;
               // pins are sampled here, in the first state
               unique case (idx)
                  `MPIO_IDX_INT_PORT:
                     // upper bits have no meaning and read as zero
                     rdata_nxt[0] = rmw ? int_latch_r
                                        : interrupt_pin_in;
                  `MPIO_IDX_SIX_PORT:
                     rdata_nxt[7:0] = mpio_read_view({2'b00, six_bit_port_in},
                        {2'b00, six_latch}, {2'b00, six_dir}, rmw);
                  `MPIO_IDX_PWM_PORT:
                     rdata_nxt[7:0] = mpio_read_view(pwm_port_in, pwm_latch,
                        pwm_dir, rmw);
                  `MPIO_IDX_MIXED_PORT:
                     rdata_nxt[7:0] = mpio_read_view(mixed_port_in, mix_latch,
                        mix_dir, rmw);
                  `MPIO_IDX_VIDEO_PORT:
                     rdata_nxt[7:0] = mpio_read_view(video_port_in, vid_latch,
                        vid_dir, rmw);
                  `MPIO_IDX_CTRL:
                     rdata_nxt[`MPIO_CTRL_W-1:0] = ctrl_r;
                  `MPIO_IDX_VIDEO_SEL:
                     rdata_nxt[7:0] = vsel_r;
                  default:
                     rdata_nxt = 32'h0000_0000;
               endcase
            end
            if (take_wr) begin
               unique case (idx)
                  `MPIO_IDX_INT_PORT:  int_latch_nxt = wbyte[0];
                  `MPIO_IDX_CTRL:      ctrl_nxt = wbyte[`MPIO_CTRL_W-1:0];
                  `MPIO_IDX_VIDEO_SEL: vsel_nxt = wbyte;
                  default:             ;
               endcase
            end
         end
         MPIO_BUS_ANSWER: begin
            state_nxt = MPIO_BUS_SAMPLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r     <= MPIO_BUS_SAMPLE;
         waitreq_r   <= 1'b1;
         rdata_r     <= 32'h0000_0000;
         ctrl_r      <= `MPIO_CTRL_RST;
         vsel_r      <= `MPIO_VIDEO_SEL_RST;
         int_latch_r <= `MPIO_INT_LATCH_RST;
      end else begin
         state_r     <= state_nxt;
         waitreq_r   <= waitreq_nxt;
         rdata_r     <= rdata_nxt;
         ctrl_r      <= ctrl_nxt;
         vsel_r      <= vsel_nxt;
         int_latch_r <= int_latch_nxt;
      end
   end

   // pin drive: level, then open-drain or push-pull enable
   always_comb begin
      logic [7:0] lvl;
      logic       drv;
      lvl          = 8'h00;
      drv          = 1'b0;
      six_out_nxt  = six_latch & six_func_out;
      six_oe_n_nxt = ~six_dir;
      for (int i = 0; i < 2; i++) begin
         if (ctrl_r[`MPIO_CTRL_SIX_OD_LSB + i]) begin
            six_oe_n_nxt[`MPIO_SIX_OD_BIT0 + i] =
               ~(six_dir[`MPIO_SIX_OD_BIT0 + i] &
                 ~six_out_nxt[`MPIO_SIX_OD_BIT0 + i]);
         end
      end
      pwm_out_nxt  = pwm_latch & pwm_func_out;
      pwm_oe_n_nxt = ~pwm_dir;
      mix_out_nxt  = {ctrl_r[`MPIO_CTRL_MIXED_TOP] ? mix_latch[7]
                      : osd_intensity,
                      mix_latch[6:0] & mixed_func_out};
      mix_oe_n_nxt = ~mix_dir;
      for (int i = 0; i < 2; i++) begin
         if (ctrl_r[`MPIO_CTRL_MIXED_OD_LSB + i]) begin
            mix_oe_n_nxt[`MPIO_MIXED_OD_BIT0 + i] =
               ~(mix_dir[`MPIO_MIXED_OD_BIT0 + i] &
                 ~mix_out_nxt[`MPIO_MIXED_OD_BIT0 + i]);
         end
      end
      lvl = vid_latch;
      for (int i = 4; i < 8; i++) begin
         if (!vsel_r[i]) begin
            lvl[i] = osd_colour[i - 4];
         end
      end
      if (ctrl_r[`MPIO_CTRL_TEST_VIDEO]) begin
         lvl[3:0] = vid_latch[3:0] & test_video_out;
      end
      vid_out_nxt  = lvl;
      vid_oe_n_nxt = ~vid_dir;                      // upper bits
      for (int i = 0; i < `MPIO_VIDEO_OD_BITS; i++) begin
         drv = vid_dir[i] &
               (vsel_r[i] | ctrl_r[`MPIO_CTRL_TEST_VIDEO]);
         vid_oe_n_nxt[i] = ~(drv & ~lvl[i]);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         int_out_r  <= `MPIO_INT_LATCH_RST;
         int_oe_n_r <= 1'b1;
         int_prev_r <= 1'b1;
         int_fall_r <= 1'b0;
         six_out_r  <= 6'(`MPIO_LATCH_RST);
         six_oe_n_r <= 6'h3F;
         pwm_out_r  <= `MPIO_LATCH_RST;
         pwm_oe_n_r <= 8'hFF;
         mix_out_r  <= `MPIO_LATCH_RST;
         mix_oe_n_r <= 8'hFF;
         vid_out_r  <= `MPIO_LATCH_RST;
         vid_oe_n_r <= 8'hFF;
      end else begin
         int_out_r  <= int_latch_r;
         int_oe_n_r <= int_latch_r;                 // sinks only when latch is 0
         int_prev_r <= interrupt_pin_in;
         int_fall_r <= int_prev_r & ~interrupt_pin_in;
         six_out_r  <= six_out_nxt;
         six_oe_n_r <= six_oe_n_nxt;
         pwm_out_r  <= pwm_out_nxt;
         pwm_oe_n_r <= pwm_oe_n_nxt;
         mix_out_r  <= mix_out_nxt;
         mix_oe_n_r <= mix_oe_n_nxt;
         vid_out_r  <= vid_out_nxt;
         vid_oe_n_r <= vid_oe_n_nxt;
      end
   end

   assign avs_readdata       = rdata_r;
   assign avs_waitrequest    = waitreq_r;
   assign interrupt_pin_out  = int_out_r;
   assign interrupt_pin_oe_n = int_oe_n_r;
   assign ext_int_fall       = int_fall_r;
   assign six_bit_port_out   = six_out_r;
   assign six_bit_port_oe_n  = six_oe_n_r;
   assign pwm_port_out       = pwm_out_r;
   assign pwm_port_oe_n      = pwm_oe_n_r;
   assign mixed_port_out     = mix_out_r;
   assign mixed_port_oe_n    = mix_oe_n_r;
   assign video_port_out     = vid_out_r;
   assign video_port_oe_n    = vid_oe_n_r;

endmodule // mpio_top

`default_nettype wire

// ===== testbench/mpio_pin_model.sv
// outside world of one port: resolves each pin level
`timescale 1ns/10ps
`default_nettype none

module mpio_pin_model #(
   parameter int W = 8
) (
   // design side
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe_n,
   // outside driver
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   // resolved level
   output logic      [W-1:0] pin
);
   // released pins with no outside driver sit at the pull-up
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!pin_oe_n[i])
            pin[i] = pin_out[i];
         else if (ext_en[i])
            pin[i] = ext_val[i];
         else
            pin[i] = 1'b1;
      end
   end
endmodule // mpio_pin_model

`default_nettype wire

// ===== testbench/mpio_top_properties.sv
// concurrent checks on the parallel port block ports
`timescale 1ns/10ps
`default_nettype none

module mpio_chk (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   // register bus
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // pins
   input wire logic        interrupt_pin_in,
   input wire logic        interrupt_pin_out,
   input wire logic        interrupt_pin_oe_n,
   input wire logic        ext_int_fall,
   input wire logic [7:0]  pwm_port_in,
   input wire logic [7:0]  pwm_port_out,
   input wire logic [7:0]  pwm_port_oe_n,
   input wire logic [7:0]  pwm_func_out,
   input wire logic [7:0]  video_port_out,
   input wire logic [7:0]  video_port_oe_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   logic       req_seen;
   logic       wr_ok;
   logic [7:0] wd8;
   assign req_seen = (avs_read | avs_write) & avs_waitrequest;
   assign wr_ok    = req_seen & avs_write & avs_byteenable[0];
   assign wd8      = avs_writedata[7:0];

   answer_next_a: assert property (req_seen |=> !avs_waitrequest)
      else $error("bus request not answered next cycle");
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   pin_read_a: assert property (req_seen && avs_read && avs_address == 8'h04
      |=> avs_readdata[7:0] == $past(pwm_port_in))
      else $error("port read not the sampled pins");
   int_bits_a: assert property (req_seen && avs_read
      && avs_address[6:0] == 7'h02 |=> avs_readdata[31:1] == 31'h0)
      else $error("interrupt port upper bits set");
   int_drive_a: assert property (interrupt_pin_oe_n == interrupt_pin_out)
      else $error("interrupt pin drives high");
   int_fall_a: assert property ($fell(interrupt_pin_in)
      |-> ##[1:3] ext_int_fall)
      else $error("falling edge not flagged");
   fall_pulse_a: assert property (ext_int_fall |=> !ext_int_fall)
      else $error("fall flag longer than one cycle");
   dir_drive_a: assert property (wr_ok && avs_address == 8'h0C
      |=> ##1 pwm_port_oe_n == ~$past(wd8, 2))
      else $error("direction not applied to drive");
   latch_and_a: assert property (wr_ok && avs_address == 8'h04
      |=> ##1 pwm_port_out == ($past(wd8, 2) & $past(pwm_func_out)))
      else $error("pin level not latch and function");
   od_sink_a: assert property ((~video_port_oe_n[3:0]
      & video_port_out[3:0]) == 4'h0)
      else $error("open drain pin driven high");
endmodule // mpio_chk

bind mpio_top mpio_chk u_chk (.clk_sys, .nrst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .interrupt_pin_in, .interrupt_pin_out,
   .interrupt_pin_oe_n, .ext_int_fall, .pwm_port_in, .pwm_port_out,
   .pwm_port_oe_n, .pwm_func_out, .video_port_out, .video_port_oe_n);

`default_nettype wire

// ===== testbench/mpio_top_tb.sv
// self-checking bench for the parallel port block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %0t got %0h exp %0h", $time, g, e); end end

module mpio_top_tb;
   logic       clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable, osd_c, tv;
   logic       int_out, int_oe_n, int_fall, int_pin, int_x_en, int_x_v, osd_i;
   logic [5:0] six_out, six_oe_n, six_pin, six_x_en, six_x_v, six_func;
   logic [7:0] pwm_out, pwm_oe_n, pwm_pin, pwm_x_en, pwm_x_v, pwm_func;
   logic [7:0] mix_out, mix_oe_n, mix_pin, mix_x_en, mix_x_v;
   logic [7:0] vid_out, vid_oe_n, vid_pin, vid_x_en, vid_x_v;
   logic [6:0] mix_func;
   int         mismatches, n_checks;

   mpio_top dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .interrupt_pin_in(int_pin), .interrupt_pin_out(int_out),
      .interrupt_pin_oe_n(int_oe_n), .ext_int_fall(int_fall),
      .six_bit_port_in(six_pin), .six_bit_port_out(six_out),
      .six_bit_port_oe_n(six_oe_n), .pwm_port_in(pwm_pin),
      .pwm_port_out(pwm_out), .pwm_port_oe_n(pwm_oe_n),
      .mixed_port_in(mix_pin), .mixed_port_out(mix_out),
      .mixed_port_oe_n(mix_oe_n), .video_port_in(vid_pin),
      .video_port_out(vid_out), .video_port_oe_n(vid_oe_n),
      .six_func_out(six_func), .pwm_func_out(pwm_func),
      .mixed_func_out(mix_func), .osd_intensity(osd_i),
      .osd_colour(osd_c), .test_video_out(tv));

   mpio_pin_model #(.W(1)) m_int (.pin_out(int_out), .pin_oe_n(int_oe_n),
      .ext_en(int_x_en), .ext_val(int_x_v), .pin(int_pin));
   mpio_pin_model #(.W(6)) m_six (.pin_out(six_out), .pin_oe_n(six_oe_n),
      .ext_en(six_x_en), .ext_val(six_x_v), .pin(six_pin));
   mpio_pin_model #(.W(8)) m_pwm (.pin_out(pwm_out), .pin_oe_n(pwm_oe_n),
      .ext_en(pwm_x_en), .ext_val(pwm_x_v), .pin(pwm_pin));
   mpio_pin_model #(.W(8)) m_mix (.pin_out(mix_out), .pin_oe_n(mix_oe_n),
      .ext_en(mix_x_en), .ext_val(mix_x_v), .pin(mix_pin));
   mpio_pin_model #(.W(8)) m_vid (.pin_out(vid_out), .pin_oe_n(vid_oe_n),
      .ext_en(vid_x_en), .ext_val(vid_x_v), .pin(vid_pin));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // one bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      // only the watchdog ends a wait that never gets its answer
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      #1;
      `CHK({int_out, int_oe_n, six_oe_n, pwm_oe_n, mix_oe_n, vid_oe_n},
           32'hFFFFFFFF)
   endtask

   initial begin
      #100000;
      mismatches++;
      $display("BAD %0t watchdog", $time);
      finish_test();
   end

   initial begin
      int n;
      {nrst, avs_read, avs_write, int_x_en, int_x_v} = '0;
      {avs_address, avs_writedata, osd_c, tv} = '0;
      {six_x_en, six_x_v, mix_x_en, mix_x_v, vid_x_en, vid_x_v} = '0;
      {six_func, pwm_func, mix_func, osd_i} = '1;
      avs_byteenable = 4'hF;
      pwm_x_en = 8'hFF;
      pwm_x_v = 8'hA5;
      do_reset();
      `CHK({six_out, pwm_out, mix_out}, 22'h3FFFFF)
      bus(1'b0, 8'h82, 8'h00);
      `CHK(rd, 32'h1)
      bus(1'b0, 8'h0C, 8'h00);
      `CHK(rd, 32'h0)
      bus(1'b1, 8'h10, 8'h55);
      bus(1'b0, 8'h10, 8'h00);
      `CHK(rd, 32'h0)
      $display("test reset done");
      bus(1'b1, 8'h04, 8'h5A);
      settle();
      `CHK(pwm_oe_n, 8'hFF)
      bus(1'b0, 8'h04, 8'h00);
      `CHK(rd, 32'hA5)
      avs_byteenable <= 4'h0;
      bus(1'b1, 8'h04, 8'h00);
      avs_byteenable <= 4'hF;
      pwm_x_en <= 8'hF0;
      bus(1'b1, 8'h0C, 8'h0F);
      settle();
      `CHK({pwm_oe_n, pwm_out}, 16'hF05A)
      bus(1'b0, 8'h04, 8'h00);
      `CHK(rd, 32'hAA)
      pwm_func <= 8'hFE;
      bus(1'b1, 8'h04, 8'hFF);
      settle();
      bus(1'b0, 8'h04, 8'h00);
      `CHK(rd, 32'hAE)
      bus(1'b0, 8'h84, 8'h00);
      `CHK(rd, 32'hAF)
      bus(1'b1, 8'h04, rd[7:0]);
      pwm_x_en <= 8'h00;
      bus(1'b1, 8'h0C, 8'hFF);
      settle();
      `CHK(pwm_out, 8'hAE)
      $display("test pwm port done");
      bus(1'b1, 8'h02, 8'h00);
      n = 0;
      while (int_fall !== 1'b1 && n < 10) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK({int_fall, int_oe_n, int_pin}, 3'b100)
      bus(1'b0, 8'h02, 8'h00);
      `CHK(rd, 32'h0)
      bus(1'b1, 8'h02, 8'h01);
      $display("test interrupt port done");
      osd_c <= 4'h5;
      bus(1'b1, 8'h0D, 8'hFF);
      settle();
      `CHK({vid_oe_n, vid_out[7:4]}, 12'h0F5)
      bus(1'b1, 8'h06, 8'h3A);
      bus(1'b1, 8'h41, 8'hFF);
      settle();
      `CHK({vid_oe_n, vid_pin}, 16'h0A3A)
      tv <= 4'hC;
      bus(1'b1, 8'h41, 8'h00);
      bus(1'b1, 8'h40, 8'h20);
      settle();
      `CHK({vid_oe_n, vid_pin}, 16'h0858)
      $display("test video port done");
      osd_i <= 1'b0;
      mix_x_en <= 8'h02;
      bus(1'b1, 8'h08, 8'h86);
      bus(1'b1, 8'h40, 8'h0F);
      settle();
      `CHK({mix_oe_n, mix_pin}, 16'h7F7D)
      bus(1'b1, 8'h40, 8'h1F);
      settle();
      `CHK(mix_pin, 8'hFD)
      bus(1'b1, 8'h2B, 8'h30);
      bus(1'b1, 8'h03, 8'hEF);
      settle();
      `CHK({six_oe_n, six_pin}, 12'hBEF)
      $display("test open drain done");
      do_reset();
      $display("test second reset done");
      finish_test();
   end
endmodule // mpio_top_tb

`default_nettype wire
